//--- src/fsd_pkg.sv
package fsd_pkg;
	// register byte addresses on the system bus
	localparam logic [31:0] ADDR_STREAM_DEST = 32'h005f_6800;
	localparam logic [31:0] ADDR_STREAM_LEN = 32'h005f_6804;
	localparam logic [31:0] ADDR_STREAM_CTRL = 32'h005f_6808;
	localparam logic [31:0] ADDR_SORT_TABLE = 32'h005f_6810;
	localparam logic [31:0] ADDR_SORT_BASE = 32'h005f_6814;
	localparam logic [31:0] ADDR_SORT_WIDTH = 32'h005f_6818;
	localparam logic [31:0] ADDR_SORT_SHIFT = 32'h005f_681c;
	localparam logic [31:0] ADDR_SORT_CTRL = 32'h005f_6820;
	localparam logic [31:0] ADDR_BREQ_MASK = 32'h005f_6840;

	// field layouts
	localparam int FIELD_LSB = 5;
	localparam int DEST_W = 21;
	localparam int LEN_W = 19;
	localparam int TBL_W = 22;
	localparam logic [5:0] DEST_TAG = 6'h04;
	localparam logic [4:0] TBL_TAG = 5'h01;
	localparam int CTRL_BIT = 0;

	// address decode of the streaming destination and the sort zero address
	localparam logic [31:0] STREAM_ZERO_ADDR = 32'h1000_0000;
	localparam int ADDR_BIT_TEX = 24;
	localparam int ADDR_BIT_YUV = 23;
	localparam int ADDR_BIT_IMAGE = 25;
	localparam logic [31:0] SORT_ZERO_ADDR = 32'h0800_0000;

	// reset values of the control registers
	localparam logic STREAM_CTRL_RST = 1'h0;
	localparam logic SORT_CTRL_RST = 1'h0;
	localparam logic BREQ_MASK_RST = 1'h0;

	// completion event positions in the normal interrupt status word
	localparam int INT_W = 22;
	localparam int INT_BIT_STREAM = 19;
	localparam int INT_BIT_SORT = 20;

	// data movement
	localparam logic [1:0] LAST_BEAT = 2'h3;
	localparam logic [LEN_W-1:0] LEN_LAST_UNIT = 19'h0_0001;
	localparam logic [26:0] STEP_16 = 27'h000_0002;
	localparam logic [26:0] STEP_32 = 27'h000_0004;
	localparam logic [31:0] LINK_END_LIST = 32'h0000_0001;
	localparam logic [31:0] LINK_END_DMA = 32'h0000_0002;

	typedef enum logic [1:0] {
		FSD_PATH_POLY,
		FSD_PATH_YUV,
		FSD_PATH_TEX
	} fsd_path_t;

	// a zero field selects the polygon path start
	function automatic logic [31:0] fsd_stream_addr(input logic [DEST_W-1:0] dest);
		return (dest == 21'h00_0000) ? STREAM_ZERO_ADDR : {DEST_TAG, dest, 5'h00};
	endfunction

	// the image areas drop bit 25 so they decode like the lower areas
	function automatic fsd_path_t fsd_path_of(input logic [31:0] a);
		if (a[ADDR_BIT_TEX]) begin
			return FSD_PATH_TEX;
		end else if (a[ADDR_BIT_YUV]) begin
			return FSD_PATH_YUV;
		end
		return FSD_PATH_POLY;
	endfunction

	// a zero field stands for the start of system memory
	function automatic logic [31:0] fsd_sys_addr(input logic [TBL_W-1:0] f);
		return (f == 22'h00_0000) ? SORT_ZERO_ADDR : {TBL_TAG, f, 5'h00};
	endfunction
endpackage

//--- src/fsd_sort_if.sv
`timescale 1ns/1ps
interface fsd_sort_if;
	logic tbl_we;
	logic [21:0] tbl_wdata;
	logic [21:0] base;
	logic wide;
	logic shift;
	logic start;
	logic stop;
	logic [21:0] tbl_field;
	logic busy;
	logic done;

	modport ctrl (
		output tbl_we, tbl_wdata, base, wide, shift, start, stop,
		input tbl_field, busy, done
	);
	modport engine (
		input tbl_we, tbl_wdata, base, wide, shift, start, stop,
		output tbl_field, busy, done
	);
endinterface

//--- src/fsd_sort.sv
`timescale 1ns/1ps
module fsd_sort (
	input wire logic clk,
	input wire logic arst_n,
	fsd_sort_if.engine sif,
	output logic mem_req,
	output logic [31:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	output logic ref_req,
	output logic [31:0] ref_addr,
	input wire logic ref_done,
	input wire logic [31:0] ref_next_link
);
	import fsd_pkg::*;

	typedef enum {SRT_IDLE, SRT_FETCH, SRT_REF} fsd_srt_t;

	fsd_srt_t state, next_state;
	logic done, next_done;
	logic next_mem_req, next_ref_req;
	logic [31:0] next_mem_addr, next_ref_addr;
	logic [26:0] tbl_addr, next_tbl_addr;
	logic [31:0] link;
	logic [31:0] tbl_byte;
	logic [31:0] next_tbl_byte;

	assign sif.tbl_field = tbl_addr[26:5];
	assign sif.busy = (state != SRT_IDLE);
	assign sif.done = done;

	// walk the table; a stop abandons the walk and a start from idle begins anew
	always_comb begin
		next_state = state;
		next_done = 1'h0;
		next_mem_req = mem_req;
		next_ref_req = ref_req;
		next_mem_addr = mem_addr;
		next_ref_addr = ref_addr;
		next_tbl_addr = tbl_addr;
		link = 32'h0000_0000;
		tbl_byte = fsd_sys_addr(tbl_addr[26:5]) | {27'h000_0000, tbl_addr[4:0]};
		if (sif.tbl_we) begin
			next_tbl_addr = {sif.tbl_wdata, 5'h00};
		end
		case (state)
		SRT_IDLE: begin
			if (sif.start) begin
				next_state = SRT_FETCH;
				next_mem_req = 1'h1;
				next_mem_addr = {tbl_byte[31:2], 2'h0};
			end
		end
		SRT_FETCH: begin
			if (mem_ack) begin
				begin
					// a 16-bit entry picks its half of the fetched word by address bit 1
					if (sif.wide) begin
						link = mem_rdata;
					end else if (tbl_byte[1]) begin
						link = {16'h0000, mem_rdata[31:16]};
					end else begin
						link = {16'h0000, mem_rdata[15:0]};
					end
				end
				next_tbl_addr = tbl_addr + (sif.wide ? STEP_32 : STEP_16);
				next_mem_req = 1'h0;
			end
		end
		SRT_REF: begin
			if (ref_done) begin
				link = ref_next_link;
				next_ref_req = 1'h0;
			end
		end
		default: begin
			next_state = SRT_IDLE;
		end
		endcase
		// byte address of the entry that follows, used by an end-of-list link
		next_tbl_byte = fsd_sys_addr(next_tbl_addr[26:5]) | {27'h000_0000, next_tbl_addr[4:0]};
		// route the link value just obtained
		if ((state == SRT_FETCH && mem_ack) || (state == SRT_REF && ref_done)) begin
			if (link == LINK_END_DMA) begin
				next_state = SRT_IDLE;
				next_done = 1'h1;
			end else if (link == LINK_END_LIST) begin
				next_state = SRT_FETCH;
				next_mem_req = 1'h1;
				next_mem_addr = {next_tbl_byte[31:2], 2'h0};
			end else begin
				next_state = SRT_REF;
				next_ref_req = 1'h1;
				next_ref_addr = fsd_sys_addr(sif.base) +
					(sif.shift ? {link[26:0], 5'h00} : link);
			end
		end
		if (sif.stop) begin
			next_state = SRT_IDLE;
			next_mem_req = 1'h0;
			next_ref_req = 1'h0;
			next_done = 1'h0;
		end
	end

	// control state
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= SRT_IDLE;
			done <= 1'h0;
			mem_req <= 1'h0;
			ref_req <= 1'h0;
			mem_addr <= 32'h0000_0000;
			ref_addr <= 32'h0000_0000;
		end else begin
			state <= next_state;
			done <= next_done;
			mem_req <= next_mem_req;
			ref_req <= next_ref_req;
			mem_addr <= next_mem_addr;
			ref_addr <= next_ref_addr;
		end
	end

	// table pointer keeps its contents through reset
	always_ff @(posedge clk) begin
		tbl_addr <= next_tbl_addr;
	end
endmodule // fsd_sort

//--- src/fsd_top.sv
`timescale 1ns/1ps
//
// Contract
// - destination register holds bits 25-5, top six bits read 000100
// - destination range picks polygon, YUV converter or direct texture path
// - image areas at 0x12000000 up decode to the same three paths
// - direct texture destination advances as the transfer moves data
// - polygon and YUV destinations stay unchanged during the transfer
// - destination value zero means the polygon path start address
// - length bits 23-5 count 32-byte units, zero means 16 megabytes
// - length counts down so reads show the remaining bytes
// - streaming control bit 0 starts, reads busy, clears at end
// - direct texture writes use 64 or 32 bits per area select
// - table start holds bits 26-5, top five bits read 00001
// - table start advances as table entries are read
// - zero table start or link base means system address 0x08000000
// - link base holds bits 26-5 and hardware never changes it
// - link width bit selects 16-bit or 32-bit table entries
// - shift zero adds link to base, shift one adds link times 32
// - sort control bit 0 starts on one, stops on zero, reads busy
// - an interrupted sort never resumes; software reprograms and restarts
// - address, length, width, shift registers get no reset value
// - unused bits are written zero by software and read undefined
// - unlisted addresses are not written and read undefined
// - mask bit 0 gates bus request to the CPU, default unmasked
// - streaming pauses at a unit boundary while the accelerator FIFO has no free space
// - streaming end raises status bit 19, sort end bit 20
// - masking the request makes debug transfers wait long
module fsd_top (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic reg_sel,
	input wire logic reg_wr,
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rack,
	input wire logic src_valid,
	input wire logic [63:0] src_data,
	output logic src_ready,
	input wire logic [3:0] ta_free,
	output logic ta_valid,
	output logic [31:0] ta_addr,
	output logic [63:0] ta_data,
	output fsd_pkg::fsd_path_t ta_path,
	output logic ta_width32,
	input wire logic tex_width_sel0,
	input wire logic tex_width_sel1,
	output logic mem_req,
	output logic [31:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	output logic ref_req,
	output logic [31:0] ref_addr,
	input wire logic ref_done,
	input wire logic [31:0] ref_next_link,
	input wire logic ddt_bus_request_n,
	output logic cpu_bus_request_out_n,
	output logic [21:0] int_set
);
	import fsd_pkg::*;

	fsd_sort_if sif ();

	// streaming channel state
	logic running, next_running;
	logic [1:0] beat, next_beat;
	logic next_src_ready;
	logic next_ta_valid;
	logic [31:0] next_ta_addr;
	logic [63:0] next_ta_data;
	fsd_path_t next_ta_path;
	logic next_ta_width32;
	logic [INT_W-1:0] next_int_set;

	// configuration storage without reset
	logic [DEST_W-1:0] dest, next_dest;
	logic [LEN_W-1:0] len, next_len;
	logic [TBL_W-1:0] base, next_base;
	logic wide, next_wide;
	logic shift, next_shift;

	// control registers with reset
	logic breq_mask, next_breq_mask;
	logic next_breq_n;
	logic [31:0] next_rdata;
	logic next_rack;

	// bus decode
	logic wr_any, rd_any;
	logic wr_dest, wr_len, wr_sctl, wr_tbl, wr_base, wr_wide, wr_shift, wr_srt, wr_mask;
	logic accept, unit_done, last_unit;
	logic [31:0] eff_dest;
	fsd_path_t cur_path;

	assign wr_any = reg_sel && reg_wr;
	assign rd_any = reg_sel && !reg_wr;
	// unlisted addresses match no strobe, so a stray write changes nothing
	assign wr_dest = wr_any && (reg_addr == ADDR_STREAM_DEST);
	assign wr_len = wr_any && (reg_addr == ADDR_STREAM_LEN);
	assign wr_sctl = wr_any && (reg_addr == ADDR_STREAM_CTRL);
	assign wr_tbl = wr_any && (reg_addr == ADDR_SORT_TABLE);
	assign wr_base = wr_any && (reg_addr == ADDR_SORT_BASE);
	assign wr_wide = wr_any && (reg_addr == ADDR_SORT_WIDTH);
	assign wr_shift = wr_any && (reg_addr == ADDR_SORT_SHIFT);
	assign wr_srt = wr_any && (reg_addr == ADDR_SORT_CTRL);
	assign wr_mask = wr_any && (reg_addr == ADDR_BREQ_MASK);

	// current destination and the path it selects
	assign eff_dest = fsd_stream_addr(dest);
	assign cur_path = fsd_path_of(eff_dest);
	assign accept = src_valid && src_ready;
	assign unit_done = accept && (beat == LAST_BEAT);
	assign last_unit = (len == LEN_LAST_UNIT);

	// sort channel hookup; the link base is only ever loaded from the bus
	assign sif.tbl_we = wr_tbl;
	assign sif.tbl_wdata = reg_wdata[26:5];
	assign sif.base = base;
	assign sif.wide = wide;
	assign sif.shift = shift;
	assign sif.start = wr_srt && reg_wdata[CTRL_BIT] && !sif.busy;
	assign sif.stop = wr_srt && !reg_wdata[CTRL_BIT];

	fsd_sort u_sort (
		.clk(clk),
		.arst_n(arst_n),
		.sif(sif),
		.mem_req(mem_req),
		.mem_addr(mem_addr),
		.mem_ack(mem_ack),
		.mem_rdata(mem_rdata),
		.ref_req(ref_req),
		.ref_addr(ref_addr),
		.ref_done(ref_done),
		.ref_next_link(ref_next_link)
	);

	// streaming control: one 32-byte unit is four 64-bit beats
	always_comb begin
		next_running = running;
		next_beat = beat;
		next_int_set = '0;
		if (wr_sctl && reg_wdata[CTRL_BIT] && !running) begin
			next_running = 1'h1;
			next_beat = 2'h0;
		end else if (wr_sctl && !reg_wdata[CTRL_BIT]) begin
			next_running = 1'h0; // abort, no completion event
			next_beat = 2'h0;
		end else if (accept) begin
			next_beat = beat + 2'h1;
			if (unit_done && last_unit) begin
				next_running = 1'h0;
				next_int_set[INT_BIT_STREAM] = 1'h1;
			end
		end
		next_int_set[INT_BIT_SORT] = sif.done;
		// a new unit is only begun while the FIFO reports a free slot;
		// the level seen now governs the beat taken in the next cycle
		next_src_ready = next_running && (next_beat != 2'h0 || ta_free != 4'h0);
	end

	// beats forwarded to the accelerator FIFO
	always_comb begin
		next_ta_valid = accept;
		next_ta_data = accept ? src_data : ta_data;
		next_ta_path = accept ? cur_path : ta_path;
		next_ta_addr = ta_addr;
		next_ta_width32 = ta_width32;
		if (accept) begin
			if (cur_path == FSD_PATH_TEX) begin
				next_ta_addr = eff_dest + {27'h000_0000, beat, 3'h0};
				// the image area has its own width select
				next_ta_width32 = eff_dest[ADDR_BIT_IMAGE] ? tex_width_sel1 : tex_width_sel0;
			end else begin
				next_ta_addr = eff_dest;
				next_ta_width32 = 1'h0;
			end
		end
	end

	// streaming channel registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			running <= STREAM_CTRL_RST;
			beat <= 2'h0;
			src_ready <= 1'h0;
			ta_valid <= 1'h0;
			ta_addr <= 32'h0000_0000;
			ta_data <= 64'h0000_0000_0000_0000;
			ta_path <= FSD_PATH_POLY;
			ta_width32 <= 1'h0;
			int_set <= '0;
		end else begin
			running <= next_running;
			beat <= next_beat;
			src_ready <= next_src_ready;
			ta_valid <= next_ta_valid;
			ta_addr <= next_ta_addr;
			ta_data <= next_ta_data;
			ta_path <= next_ta_path;
			ta_width32 <= next_ta_width32;
			int_set <= next_int_set;
		end
	end

	// configuration next values; bus writes always land, so rewriting
	// during a transfer corrupts it and is left to software
	always_comb begin
		next_dest = dest;
		next_len = len;
		next_base = base;
		next_wide = wide;
		next_shift = shift;
		if (unit_done) begin
			next_len = len - LEN_LAST_UNIT;
			if (cur_path == FSD_PATH_TEX) begin
				next_dest = dest + 21'h00_0001;
			end
		end
		if (wr_dest) begin
			next_dest = reg_wdata[25:5];
		end
		if (wr_len) begin
			next_len = reg_wdata[23:5];
		end
		if (wr_base) begin
			next_base = reg_wdata[26:5];
		end
		if (wr_wide) begin
			next_wide = reg_wdata[CTRL_BIT];
		end
		if (wr_shift) begin
			next_shift = reg_wdata[CTRL_BIT];
		end
	end

	// these hold their contents across reset, so no reset branch
	always_ff @(posedge clk) begin
		dest <= next_dest;
		len <= next_len;
		base <= next_base;
		wide <= next_wide;
		shift <= next_shift;
	end

	// read mux and bus request gating
	always_comb begin
		next_breq_mask = wr_mask ? reg_wdata[CTRL_BIT] : breq_mask;
		// while masked the debug channel's request never reaches the CPU
		next_breq_n = breq_mask ? 1'h1 : ddt_bus_request_n;
		next_rack = rd_any;
		next_rdata = 32'h0000_0000;
		// reserved bits and unlisted addresses read zero
		if (rd_any) begin
			case (reg_addr)
			ADDR_STREAM_DEST: next_rdata = {DEST_TAG, dest, 5'h00};
			ADDR_STREAM_LEN: next_rdata = {8'h00, len, 5'h00};
			ADDR_STREAM_CTRL: next_rdata = {31'h0000_0000, running};
			ADDR_SORT_TABLE: next_rdata = {TBL_TAG, sif.tbl_field, 5'h00};
			ADDR_SORT_BASE: next_rdata = {TBL_TAG, base, 5'h00};
			ADDR_SORT_WIDTH: next_rdata = {31'h0000_0000, wide};
			ADDR_SORT_SHIFT: next_rdata = {31'h0000_0000, shift};
			ADDR_SORT_CTRL: next_rdata = {31'h0000_0000, sif.busy};
			ADDR_BREQ_MASK: next_rdata = {31'h0000_0000, breq_mask};
			default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// register-side flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			breq_mask <= BREQ_MASK_RST;
			cpu_bus_request_out_n <= 1'h1;
			reg_rdata <= 32'h0000_0000;
			reg_rack <= 1'h0;
		end else begin
			breq_mask <= next_breq_mask;
			cpu_bus_request_out_n <= next_breq_n;
			reg_rdata <= next_rdata;
			reg_rack <= next_rack;
		end
	end
endmodule // fsd_top

//--- tb/fsd_top_props.sv
`timescale 1ns/1ps
module fsd_props
	import fsd_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic reg_sel,
	input wire logic reg_wr,
	input wire logic reg_rack,
	input wire logic src_valid,
	input wire logic src_ready,
	input wire logic ta_valid,
	input wire logic [31:0] ta_addr,
	input wire fsd_pkg::fsd_path_t ta_path,
	input wire logic ta_width32,
	input wire logic mem_ack,
	input wire logic ref_done,
	input wire logic ddt_bus_request_n,
	input wire logic cpu_bus_request_out_n,
	input wire logic [21:0] int_set
);
	logic in_run;
	logic [31:0] prev_addr;

	// previous beat of one transfer; only the end event closes it, so a run after an abort is checked against the aborted one
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			in_run <= 1'b0;
			prev_addr <= 32'h0000_0000;
		end else begin
			in_run <= (in_run | ta_valid) & ~int_set[19];
			if (ta_valid) begin
				prev_addr <= ta_addr;
			end
		end
	end

	default clocking @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	a_read_answer: assert property (reg_sel && !reg_wr |=> reg_rack)
		else $error("read got no answer");
	a_beat_forward: assert property (src_valid && src_ready |=> ta_valid)
		else $error("taken beat not forwarded");
	a_path_decode: assert property (ta_valid |-> ta_path == (ta_addr[24] ? FSD_PATH_TEX :
		(ta_addr[23] ? FSD_PATH_YUV : FSD_PATH_POLY))) else $error("path decode wrong");
	a_tex_step: assert property (ta_valid && in_run && ta_path == FSD_PATH_TEX |->
		ta_addr == prev_addr + 32'h0000_0008) else $error("texture address not advanced");
	a_fifo_dest_hold: assert property (ta_valid && in_run && ta_path != FSD_PATH_TEX |->
		ta_addr == prev_addr) else $error("fifo destination moved");
	a_width_tex_only: assert property (ta_valid && ta_path != FSD_PATH_TEX |-> !ta_width32)
		else $error("width select outside texture path");
	a_stream_end_beat: assert property (int_set[19] |-> ta_valid)
		else $error("stream end without last beat");
	a_sort_end_cause: assert property (int_set[20] |-> $past(mem_ack || ref_done, 2))
		else $error("sort end without answer");
	a_breq_pass: assert property (ddt_bus_request_n |=> cpu_bus_request_out_n)
		else $error("bus request raised without cause");

	c_stream_end: cover property (int_set[19]);
	c_sort_end: cover property (int_set[20]);
	c_tex_beat: cover property (ta_valid && ta_path == FSD_PATH_TEX);
endmodule // fsd_props

bind fsd_top fsd_props chk (.clk, .arst_n, .reg_sel, .reg_wr, .reg_rack, .src_valid, .src_ready,
	.ta_valid, .ta_addr, .ta_path, .ta_width32, .mem_ack, .ref_done, .ddt_bus_request_n,
	.cpu_bus_request_out_n, .int_set);

//--- tb/fsd_partner.sv
`timescale 1ns/1ps
module fsd_partner (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic src_en,
	input wire logic [4:0] dly,
	input wire logic src_ready,
	output logic src_valid,
	output logic [63:0] src_data,
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	output logic mem_ack,
	output logic [31:0] mem_rdata,
	input wire logic ref_req,
	output logic ref_done,
	output logic [31:0] ref_next_link
);
	logic [31:0] tbl [8];
	logic [31:0] nxt;
	logic [31:0] cnt;
	logic [4:0] wt;

	// data moves only on a taken beat, so it holds while the device stalls
	assign src_valid = src_en;
	assign src_data = {~cnt, cnt};

	// memory answers dly+1 cycles after a request; released data toggles so stale values never match
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= 32'h0000_0000;
			wt <= 5'h00;
			mem_ack <= 1'b0;
			ref_done <= 1'b0;
			mem_rdata <= 32'h5555_5555;
			ref_next_link <= 32'haaaa_aaaa;
		end else begin
			if (src_valid && src_ready) begin
				cnt <= cnt + 32'h0000_0001;
			end
			mem_ack <= 1'b0;
			ref_done <= 1'b0;
			mem_rdata <= ~mem_rdata;
			ref_next_link <= ~ref_next_link;
			wt <= (mem_req || ref_req) ? wt + 5'h01 : 5'h00;
			if (wt >= dly && mem_req && !mem_ack) begin
				mem_ack <= 1'b1;
				mem_rdata <= tbl[mem_addr[4:2]];
				wt <= 5'h00;
			end
			if (wt >= dly && ref_req && !ref_done) begin
				ref_done <= 1'b1;
				ref_next_link <= nxt;
				wt <= 5'h00;
			end
		end
	end
endmodule // fsd_partner

//--- tb/fsd_tb_top.sv
`timescale 1ns/1ps
`define CHK(s, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED %s exp %h seen %h", s, e, g); end end
module fsd_tb_top;
	import fsd_pkg::*;
	logic clk, arst_n, reg_sel, reg_wr, reg_rack, src_valid, src_ready, ta_valid, ta_width32;
	logic tex_width_sel0, tex_width_sel1, mem_req, mem_ack, ref_req, ref_done, src_en, lw;
	logic ddt_bus_request_n, cpu_bus_request_out_n;
	logic [31:0] reg_addr, reg_wdata, reg_rdata, ta_addr, mem_addr, mem_rdata, ref_addr;
	logic [31:0] ref_next_link, first_addr, last_addr, raddr, nd;
	logic [31:0] maddr [4];
	logic [63:0] src_data, ta_data;
	logic [3:0] ta_free;
	logic [4:0] dly;
	logic [21:0] int_set;
	fsd_path_t ta_path, lpath;
	int n_errors, num_checks, nbeat, nmem, nr, got19, got20, n1;

	always #2 clk = ~clk;

	fsd_top dut (.clk, .arst_n, .reg_sel, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .reg_rack,
		.src_valid, .src_data, .src_ready, .ta_free, .ta_valid, .ta_addr, .ta_data, .ta_path,
		.ta_width32, .tex_width_sel0, .tex_width_sel1, .mem_req, .mem_addr, .mem_ack, .mem_rdata,
		.ref_req, .ref_addr, .ref_done, .ref_next_link, .ddt_bus_request_n,
		.cpu_bus_request_out_n, .int_set);
	fsd_partner part (.clk, .arst_n, .src_en, .dly, .src_ready, .src_valid, .src_data, .mem_req,
		.mem_addr, .mem_ack, .mem_rdata, .ref_req, .ref_done, .ref_next_link);

	// record what reaches the fifo and memory, and the end events
	always @(posedge clk) begin
		if (ta_valid) begin
			`CHK("data", {~nd, nd}, ta_data)
			nd++;
			if (nbeat == 0) first_addr = ta_addr;
			nbeat++;
			last_addr = ta_addr;
			lpath = ta_path;
			lw = ta_width32;
		end
		if (mem_req && mem_ack && nmem < 4) begin
			maddr[nmem] = mem_addr;
			nmem++;
		end
		if (ref_req && ref_done) begin
			raddr = ref_addr;
			nr++;
		end
		got19 += int_set[19];
		got20 += int_set[20];
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(negedge clk);
		reg_sel = 1'b1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_sel = 1'b0;
		reg_wr = 1'b0;
	endtask

	// the answer is registered on the taking edge itself, so look at the next falling edge
	task automatic rd(input logic [31:0] a, input logic [31:0] e, input string s);
		@(negedge clk);
		reg_sel = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_sel = 1'b0;
		`CHK("read answer", 1'b1, reg_rack)
		`CHK(s, e, reg_rdata)
	endtask

	task automatic wait_ev(ref int v, input int target);
		for (int i = 0; i < 400 && v < target; i++) @(negedge clk);
		if (v < target) begin
			n_errors++;
			$display("CHECK FAILED wait exp %0d seen %0d", target, v);
			end_of_test();
		end
	endtask

	task automatic strm(input logic [31:0] d, input logic [31:0] len, input fsd_path_t p,
		input logic w);
		logic [31:0] base;
		logic [31:0] fin;
		base = (d == 32'h0000_0000) ? 32'h1000_0000 : d;
		fin = base + ((p == FSD_PATH_TEX) ? len : 32'h0000_0000);
		wr(ADDR_STREAM_LEN, len);
		wr(ADDR_STREAM_DEST, d);
		rd(ADDR_STREAM_DEST, {6'h04, d[25:5], 5'h00}, "dest");
		nbeat = 0;
		got19 = 0;
		wr(ADDR_STREAM_CTRL, 32'h0000_0001);
		wait_ev(got19, 1);
		`CHK("beats", len / 8, nbeat)
		`CHK("first addr", base, first_addr)
		`CHK("last addr", fin - ((p == FSD_PATH_TEX) ? 8 : 0), last_addr)
		`CHK("path", p, lpath)
		`CHK("width", w, lw)
		rd(ADDR_STREAM_CTRL, 32'h0000_0000, "ctrl");
		rd(ADDR_STREAM_LEN, 32'h0000_0000, "len");
		rd(ADDR_STREAM_DEST, {6'h04, fin[25:5], 5'h00}, "dest after");
		$display("stream test %h done", d);
	endtask

	// software writes zero to unused bits and leaves config alone while running
	task automatic srt(input logic [31:0] tf, input logic [31:0] bf, input logic w,
		input logic s, input logic [31:0] e_ref, input int e_nr);
		wr(ADDR_SORT_TABLE, tf);
		wr(ADDR_SORT_BASE, bf);
		wr(ADDR_SORT_WIDTH, {31'h0000_0000, w});
		wr(ADDR_SORT_SHIFT, {31'h0000_0000, s});
		rd(ADDR_SORT_TABLE, tf, "table");
		nmem = 0;
		nr = 0;
		got20 = 0;
		wr(ADDR_SORT_CTRL, 32'h0000_0001);
		wait_ev(got20, 1);
		`CHK("refs", e_nr, nr)
		`CHK("table first", tf, maddr[0])
		if (e_nr > 0) `CHK("ref addr", e_ref, raddr)
		if (w) `CHK("next entry", maddr[0] + 4, maddr[1])
		rd(ADDR_SORT_CTRL, 32'h0000_0000, "sort idle");
		rd(ADDR_SORT_BASE, (bf == 0) ? 32'h0800_0000 : bf, "base kept");
		$display("sort test %h done", bf);
	endtask

	initial begin
		clk = 1'b0;
		arst_n = 1'b0;
		reg_sel = 1'b0;
		reg_wr = 1'b0;
		reg_addr = 32'h0000_0000;
		reg_wdata = 32'h0000_0000;
		src_en = 1'b0;
		dly = 5'h00;
		ta_free = 4'h4;
		tex_width_sel0 = 1'b1;
		tex_width_sel1 = 1'b0;
		ddt_bus_request_n = 1'b1;
		n_errors = 0;
		num_checks = 0;
		nbeat = 0;
		nmem = 0;
		nr = 0;
		nd = 32'h0000_0000;
		repeat (3) @(posedge clk);
		@(negedge clk);
		arst_n = 1'b1;
		src_en = 1'b1;
		rd(ADDR_STREAM_CTRL, 32'h0000_0000, "ctrl reset");
		rd(ADDR_SORT_CTRL, 32'h0000_0000, "sort reset");
		rd(ADDR_BREQ_MASK, 32'h0000_0000, "mask reset");
		rd(32'h005f_680c, 32'h0000_0000, "unmapped");
		ddt_bus_request_n = 1'b0;
		repeat (2) @(negedge clk);
		`CHK("breq open", 1'b0, cpu_bus_request_out_n)
		wr(ADDR_BREQ_MASK, 32'h0000_0001);
		repeat (2) @(negedge clk);
		`CHK("breq masked", 1'b1, cpu_bus_request_out_n)
		wr(ADDR_BREQ_MASK, 32'h0000_0000);
		ddt_bus_request_n = 1'b1;
		$display("bus request test done");
		strm(32'h1100_0000, 32'h0000_0040, FSD_PATH_TEX, 1'b1);
		strm(32'h1080_0000, 32'h0000_0040, FSD_PATH_YUV, 1'b0);
		strm(32'h0000_0000, 32'h0000_0020, FSD_PATH_POLY, 1'b0);
		strm(32'h1200_0020, 32'h0000_0040, FSD_PATH_POLY, 1'b0);
		strm(32'h1300_0000, 32'h0000_0020, FSD_PATH_TEX, 1'b0);
		// zero length runs long, so stall it at a unit boundary and abort
		ta_free = 4'h0;
		wr(ADDR_STREAM_LEN, 32'h0000_0000);
		wr(ADDR_STREAM_DEST, 32'h1000_0000);
		nbeat = 0;
		got19 = 0;
		wr(ADDR_STREAM_CTRL, 32'h0000_0001);
		repeat (10) @(negedge clk);
		`CHK("stalled", 0, nbeat)
		rd(ADDR_STREAM_CTRL, 32'h0000_0001, "busy");
		ta_free = 4'h4;
		wait_ev(nbeat, 8);
		ta_free = 4'h0;
		repeat (12) @(negedge clk);
		n1 = nbeat;
		rd(ADDR_STREAM_LEN, 32'h0100_0000 - n1 * 8, "remaining");
		`CHK("paused", n1, nbeat)
		`CHK("unit boundary", 0, n1 % 4)
		wr(ADDR_STREAM_CTRL, 32'h0000_0000);
		ta_free = 4'h4;
		repeat (10) @(negedge clk);
		`CHK("no end event", 0, got19)
		rd(ADDR_STREAM_CTRL, 32'h0000_0000, "aborted");
		$display("stall test done");
		part.tbl[0] = 32'h0000_0040;
		part.tbl[1] = 32'h0000_0002;
		part.nxt = 32'h0000_0001;
		srt(32'h0800_2000, 32'h0000_0000, 1'b1, 1'b0, 32'h0800_0040, 1);
		dly = 5'h03;
		srt(32'h0800_2000, 32'h0800_0060, 1'b1, 1'b1, 32'h0800_0860, 1);
		part.tbl[0] = 32'h0002_0001;
		srt(32'h0800_2000, 32'h0800_0060, 1'b0, 1'b0, 32'h0000_0000, 0);
		// stop while memory is slow, then restart from scratch
		part.tbl[0] = 32'h0000_0040;
		dly = 5'h14;
		got20 = 0;
		nmem = 0;
		wr(ADDR_SORT_WIDTH, 32'h0000_0001);
		wr(ADDR_SORT_CTRL, 32'h0000_0001);
		repeat (5) @(negedge clk);
		wr(ADDR_SORT_CTRL, 32'h0000_0000);
		repeat (30) @(negedge clk);
		`CHK("stopped event", 0, got20)
		`CHK("stopped reads", 0, nmem)
		rd(ADDR_SORT_CTRL, 32'h0000_0000, "sort stopped");
		dly = 5'h00;
		srt(32'h0800_4000, 32'h0800_0060, 1'b1, 1'b0, 32'h0800_00a0, 1);
		end_of_test();
	end
endmodule // fsd_tb_top
